// File: bii_irq.sv
// Internal interrupt sources with AXI4-Lite register file
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
// How it works
// - PCI soft interrupt on trigger rising edge
// - Soft status stays set while source active
// - PCI soft irq on line from map one
// - Clearing trigger bit withdraws soft interrupt
// - Shared level IACK returns soft ID, LSB 0
// - Soft irq released on acknowledge if alone
// - Status shows all active sources together
// - Soft ID supplied creates ack event
// - Ack event has enable, map, status; PCI only
// - Ownership irq once bus acquired on request
// - Write one clears ownership status
// - Six DMA causes ORed into one line
// - DMA mappable to VME or PCI; causes readable
// - Mailbox write raises own mapped interrupt
// - Monitor hit needs enable, space, 4k window
// - Address bits 4:3 select monitor one to four
// - Monitors map to PCI only, LM status
// - Error irq only for decoupled write errors
// - Auto-ID asserts level 2 before sysfail release
// - Level 2 IACK answers 0xFE, opens CR/CSR
// - VME trigger write acts only when bit 0
module bii_irq (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic bus_acquired,
  input wire logic [bii_pkg::NCAUSE-1:0] dma_cause,
  input wire logic [3:0] mbox_write,
  input wire logic decoupled_write,
  input wire logic vme_bus_error,
  input wire logic pci_abort,
  input wire bii_pkg::bii_vacc_s vme_access,
  input wire bii_pkg::bii_iack_s vme_iack,
  input wire logic autoid_option,
  output logic iack_hit,
  output logic [7:0] iack_statid,
  output logic [bii_pkg::NPCI-1:0] pci_irq_outputs,
  output logic [bii_pkg::NVME-1:1] vme_irq,
  output logic sysfail_release,
  output logic crcsr_enable,
  output logic [31:0] crcsr_base,
  output logic bus_ownership_request
);
  localparam int N = bii_pkg::NSRC;
  localparam int M = bii_pkg::MAPW;

  // Registers
  logic [31:0] pci_irq_enable_reg_ff;
  logic [31:0] vme_irq_enable_reg_ff;
  logic [N-1:0] pci_stat_ff;
  logic [N-1:0] vme_stat_ff;
  logic [N*M-1:0] pci_map_ff;
  logic [N*M-1:0] vme_map_ff;
  logic [31:0] master_control_reg_ff;
  logic [31:0] location_monitor_base_ff;
  logic [7:0] lm_ctl_ff;
  logic [7:0] sw_statid_ff;
  logic [bii_pkg::NCAUSE-1:0] dma_cause_ff;
  logic vme_sw_ff;
  logic autoid_pend_ff;
  logic crcsr_en_ff;
  logic started_ff;

  // AXI write and read channel state
  logic aw_got_ff, w_got_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic bvalid_ff, bresp_err_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  // Map field of one source
  function automatic logic [M-1:0] map_of(input logic [N*M-1:0] m, input int i);
    map_of = m[i*M +: M];
  endfunction : map_of

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = s[b] ? d[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction : merge

  logic wr_fire;
  logic [31:0] wval;
  assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready = !w_got_ff && !bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_err_ff ? bii_pkg::RESP_SLVERR : bii_pkg::RESP_OKAY;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // Address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_got_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_got_ff <= 1'b0;
      end
    end
  end

  logic wr_known;
  always_comb begin
    unique case (aw_addr_ff)
      bii_pkg::ADDR_PCI_EN, bii_pkg::ADDR_PCI_STAT, bii_pkg::ADDR_PCI_MAP1, bii_pkg::ADDR_PCI_MAP2,
      bii_pkg::ADDR_VME_EN, bii_pkg::ADDR_VME_STAT, bii_pkg::ADDR_VME_MAP1, bii_pkg::ADDR_VME_MAP2,
      bii_pkg::ADDR_MASTER_CONTROL_REG, bii_pkg::ADDR_LM_BASE, bii_pkg::ADDR_LM_CTL, bii_pkg::ADDR_SWID: wr_known = 1'b1;
      default: wr_known = 1'b0;
    endcase
  end

  // Write response one cycle after both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_err_ff <= 1'b0;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_err_ff <= !wr_known;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  function automatic logic wr_to(input logic [7:0] a);
    wr_to = wr_fire && (aw_addr_ff == a);
  endfunction : wr_to

  // A 1 written over a trigger bit that is still 0
  function automatic logic trig_wr(input logic [7:0] a, input logic old_bit);
    trig_wr = wr_to(a) && w_strb_ff[0] && w_data_ff[bii_pkg::B_SW] && !old_bit;
  endfunction : trig_wr

  // Event detection
  logic pci_sw_rise, sw_ack_evt, own_evt, lm_hit, verr_evt, lerr_evt, autoid_ack;
  logic [3:0] lm_sel;
  logic [N-1:0] pci_set, vme_set;
  logic [31:0] lm_in_en;
  // Write value with strobed-off bytes as zero
  assign wval = merge(32'h0000_0000, w_data_ff, w_strb_ff);
  // Edge taken at the write itself, so status and enable land together
  always_comb begin
    pci_sw_rise = trig_wr(bii_pkg::ADDR_PCI_EN, pci_irq_enable_reg_ff[bii_pkg::B_SW]);
  end
  assign own_evt = bus_acquired && master_control_reg_ff[bii_pkg::B_OWN_REQ];
  assign verr_evt = vme_bus_error && decoupled_write;
  assign lerr_evt = pci_abort && decoupled_write;
  assign lm_in_en = pci_irq_enable_reg_ff;
  // Window compare on bits above 4k, plus enable and space
  assign lm_hit = vme_access.valid && lm_ctl_ff[bii_pkg::B_LM_EN] &&
                  (vme_access.space == lm_ctl_ff[bii_pkg::LM_SPACE_LSB +: 2]) &&
                  (vme_access.addr[bii_pkg::VA_W-1:bii_pkg::LM_SPAN_BITS] ==
                   location_monitor_base_ff[bii_pkg::VA_W-1:bii_pkg::LM_SPAN_BITS]);
  // One-hot monitor pick; only the addressed copy can be set
  always_comb begin
    lm_sel = 4'h0;
    lm_sel[vme_access.addr[bii_pkg::LM_SEL_LSB +: 2]] = lm_hit;
  end
  // Auto-ID owns level 2 until acknowledged, ahead of the soft source
  assign autoid_ack = vme_iack.valid && autoid_pend_ff && (vme_iack.level == bii_pkg::AUTOID_LEVEL);
  assign sw_ack_evt = vme_iack.valid && !autoid_ack && vme_sw_ff &&
                      (vme_iack.level == map_of(vme_map_ff, bii_pkg::B_SW));

  always_comb begin
    pci_set = '0;
    pci_set[bii_pkg::B_SWACK] = sw_ack_evt;
    pci_set[bii_pkg::B_OWN] = own_evt;
    pci_set[bii_pkg::B_DMA] = |dma_cause;
    pci_set[bii_pkg::B_VERR] = verr_evt;
    pci_set[bii_pkg::B_LERR] = lerr_evt;
    pci_set[bii_pkg::B_MBOX +: 4] = mbox_write;
    pci_set[bii_pkg::B_LM +: 4] = lm_sel;
    vme_set = pci_set;
    vme_set[bii_pkg::B_SWACK] = 1'b0;
    vme_set[bii_pkg::B_OWN] = 1'b0;
    vme_set[bii_pkg::B_LM +: 4] = 4'h0;
  end

  // Enable, map and control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pci_irq_enable_reg_ff <= 32'h0000_0000;
      vme_irq_enable_reg_ff <= 32'h0000_0000;
      pci_map_ff <= '0;
      vme_map_ff <= '0;
      master_control_reg_ff <= 32'h0000_0000;
      location_monitor_base_ff <= 32'h0000_0000;
      lm_ctl_ff <= 8'h00;
      sw_statid_ff <= 8'h00;
    end else begin
      if (wr_to(bii_pkg::ADDR_PCI_EN)) pci_irq_enable_reg_ff <= merge(pci_irq_enable_reg_ff, w_data_ff, w_strb_ff);
      if (wr_to(bii_pkg::ADDR_VME_EN)) vme_irq_enable_reg_ff <= merge(vme_irq_enable_reg_ff, w_data_ff, w_strb_ff);
      if (wr_to(bii_pkg::ADDR_PCI_MAP1)) pci_map_ff[31:0] <= merge(pci_map_ff[31:0], w_data_ff, w_strb_ff);
      if (wr_to(bii_pkg::ADDR_PCI_MAP2)) pci_map_ff[N*M-1:32] <= wval[N*M-33:0];
      if (wr_to(bii_pkg::ADDR_VME_MAP1)) vme_map_ff[31:0] <= merge(vme_map_ff[31:0], w_data_ff, w_strb_ff);
      if (wr_to(bii_pkg::ADDR_VME_MAP2)) vme_map_ff[N*M-1:32] <= wval[N*M-33:0];
      if (wr_to(bii_pkg::ADDR_MASTER_CONTROL_REG)) master_control_reg_ff <= merge(master_control_reg_ff, w_data_ff, w_strb_ff);
      if (wr_to(bii_pkg::ADDR_LM_BASE)) location_monitor_base_ff <= merge(location_monitor_base_ff, w_data_ff, w_strb_ff);
      if (wr_to(bii_pkg::ADDR_LM_CTL)) lm_ctl_ff <= wval[7:0];
      if (wr_to(bii_pkg::ADDR_SWID)) sw_statid_ff <= {wval[7:1], 1'b0};
    end
  end
  assign bus_ownership_request = master_control_reg_ff[bii_pkg::B_OWN_REQ];

  // VME software source: set only on write of 1 over a 0
  logic vme_trig_wr;
  always_comb begin
    vme_trig_wr = trig_wr(bii_pkg::ADDR_VME_EN, vme_irq_enable_reg_ff[bii_pkg::B_SW]);
  end
  // Another enabled source on the acknowledged level keeps the soft one alive
  logic vme_other_same;
  always_comb begin
    vme_other_same = 1'b0;
    for (int i = 1; i < N; i++) begin
      if (vme_stat_ff[i] && vme_irq_enable_reg_ff[i] && map_of(vme_map_ff, i) == vme_iack.level)
        vme_other_same = 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vme_sw_ff <= 1'b0;
    end else if (vme_trig_wr) begin
      vme_sw_ff <= 1'b1;
    end else if (!vme_irq_enable_reg_ff[bii_pkg::B_SW]) begin
      vme_sw_ff <= 1'b0;
    end else if (sw_ack_evt && !vme_other_same) begin
      vme_sw_ff <= 1'b0;
    end
  end

  // Sticky status; set wins over write-one-clear
  logic [N-1:0] pci_clr, vme_clr;
  // Process, not assign: the decode reads state hidden behind the function
  always_comb begin
    pci_clr = wr_to(bii_pkg::ADDR_PCI_STAT) ? wval[N-1:0] : '0;
    vme_clr = wr_to(bii_pkg::ADDR_VME_STAT) ? wval[N-1:0] : '0;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pci_stat_ff <= '0;
      vme_stat_ff <= '0;
    end else begin
      pci_stat_ff <= (pci_stat_ff & ~pci_clr) | pci_set;
      vme_stat_ff <= (vme_stat_ff & ~vme_clr) | vme_set;
      // Soft status follows its source while active
      pci_stat_ff[bii_pkg::B_SW] <= pci_sw_rise || (pci_stat_ff[bii_pkg::B_SW] &&
                                    pci_irq_enable_reg_ff[bii_pkg::B_SW]);
      vme_stat_ff[bii_pkg::B_SW] <= vme_sw_ff;
    end
  end

  // DMA cause bits, sticky, cleared by DMA status write
  always_ff @(posedge aclk) begin
    if (!aresetn) dma_cause_ff <= '0;
    else if (pci_clr[bii_pkg::B_DMA] || vme_clr[bii_pkg::B_DMA]) dma_cause_ff <= dma_cause;
    else dma_cause_ff <= dma_cause_ff | dma_cause;
  end

  // Output routing: OR of enabled active sources per line
  always_comb begin
    pci_irq_outputs = '0;
    vme_irq = '0;
    for (int i = 0; i < N; i++) begin
      if (pci_stat_ff[i] && pci_irq_enable_reg_ff[i] && !(i == bii_pkg::B_SW && !lm_in_en[i]))
        pci_irq_outputs[map_of(pci_map_ff, i)] = 1'b1;
      // VME soft skips the enable gate: its enable bit is the trigger
      if (vme_stat_ff[i] && (vme_irq_enable_reg_ff[i] || i == bii_pkg::B_SW) && map_of(vme_map_ff, i) != 3'h0)
        vme_irq[map_of(vme_map_ff, i)] = 1'b1;
    end
    if (autoid_pend_ff) vme_irq[bii_pkg::AUTOID_LEVEL] = 1'b1;
  end

  // Auto-ID: strap caught after reset release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      started_ff <= 1'b0;
      autoid_pend_ff <= 1'b0;
      crcsr_en_ff <= 1'b0;
    end else begin
      started_ff <= 1'b1;
      if (!started_ff) autoid_pend_ff <= autoid_option;
      else if (autoid_ack) autoid_pend_ff <= 1'b0;
      if (autoid_ack) crcsr_en_ff <= 1'b1;
    end
  end
  assign sysfail_release = started_ff && !autoid_pend_ff;
  assign crcsr_enable = crcsr_en_ff;
  assign crcsr_base = bii_pkg::CRCSR_BASE;

  // IACK answer
  assign iack_hit = autoid_ack || sw_ack_evt;
  assign iack_statid = autoid_ack ? bii_pkg::AUTOID_STATID : (sw_ack_evt ? sw_statid_ff : 8'h00);

  // Read path
  logic [31:0] rd_val;
  logic rd_ok;
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      bii_pkg::ADDR_PCI_EN: rd_val = pci_irq_enable_reg_ff;
      bii_pkg::ADDR_PCI_STAT: rd_val = {{(32-N-bii_pkg::NCAUSE){1'b0}}, dma_cause_ff, pci_stat_ff};
      bii_pkg::ADDR_PCI_MAP1: rd_val = pci_map_ff[31:0];
      bii_pkg::ADDR_PCI_MAP2: rd_val = {{(64-N*M){1'b0}}, pci_map_ff[N*M-1:32]};
      bii_pkg::ADDR_VME_EN: rd_val = vme_irq_enable_reg_ff;
      bii_pkg::ADDR_VME_STAT: rd_val = {{(32-N-bii_pkg::NCAUSE){1'b0}}, dma_cause_ff, vme_stat_ff};
      bii_pkg::ADDR_VME_MAP1: rd_val = vme_map_ff[31:0];
      bii_pkg::ADDR_VME_MAP2: rd_val = {{(64-N*M){1'b0}}, vme_map_ff[N*M-1:32]};
      bii_pkg::ADDR_MASTER_CONTROL_REG: rd_val = master_control_reg_ff;
      bii_pkg::ADDR_LM_BASE: rd_val = location_monitor_base_ff;
      bii_pkg::ADDR_LM_CTL: rd_val = {24'h00_0000, lm_ctl_ff};
      bii_pkg::ADDR_SWID: rd_val = {24'h00_0000, sw_statid_ff};
      default: rd_ok = 1'b0;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= bii_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_val;
      rresp_ff <= rd_ok ? bii_pkg::RESP_OKAY : bii_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
endmodule : bii_irq

// File: bii_irq_props.sv
// Port checker for the internal interrupt block
`timescale 1ns/1ns
module bii_irq_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic bus_acquired,
  input wire logic [bii_pkg::NCAUSE-1:0] dma_cause,
  input wire logic [3:0] mbox_write,
  input wire logic vme_bus_error,
  input wire logic pci_abort,
  input wire bii_pkg::bii_vacc_s vme_access,
  input wire bii_pkg::bii_iack_s vme_iack,
  input wire logic autoid_option,
  input wire logic iack_hit,
  input wire logic [7:0] iack_statid,
  input wire logic [bii_pkg::NPCI-1:0] pci_irq_outputs,
  input wire logic [bii_pkg::NVME-1:1] vme_irq,
  input wire logic sysfail_release,
  input wire logic crcsr_enable,
  input wire logic [31:0] crcsr_base
);
  logic lvl_on;
  logic ev_any;
  // Acknowledged level is driven; any event other than IACK or a register write that may set a status bit
  assign lvl_on = |({vme_irq, 1'b0} & (8'h01 << vme_iack.level));
  assign ev_any = bus_acquired || (|dma_cause) || (|mbox_write) || vme_bus_error || pci_abort || vme_access.valid;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  iack_only_a: assert property (iack_hit |-> vme_iack.valid)
    else $error("answer without iack");
  statid_lsb_a: assert property (iack_hit |-> !iack_statid[0])
    else $error("status id low bit set");
  iack_level_a: assert property (iack_hit |-> lvl_on)
    else $error("answer on an idle level");
  crcsr_base_a: assert property (crcsr_base == 32'h0000_0000)
    else $error("config base not zero");
  crcsr_open_a: assert property (iack_hit && vme_iack.level == 3'h2 && iack_statid == 8'hFE |=> crcsr_enable)
    else $error("config space not opened");
  crcsr_cause_a: assert property ($rose(crcsr_enable) |-> $past(iack_hit && vme_iack.level == 3'h2))
    else $error("config space opened without iack");
  sysfail_autoid_a: assert property ($rose(sysfail_release) && autoid_option |-> crcsr_enable)
    else $error("fail line released early");
  pci_cause_a: assert property ($rose(|pci_irq_outputs) |-> s_axi_bvalid || $past(ev_any || iack_hit))
    else $error("pci line rose without cause");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
endmodule : bii_irq_props
bind bii_irq bii_irq_props props_i (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid,
  .bus_acquired, .dma_cause, .mbox_write, .vme_bus_error, .pci_abort, .vme_access, .vme_iack, .autoid_option,
  .iack_hit, .iack_statid, .pci_irq_outputs, .vme_irq, .sysfail_release, .crcsr_enable, .crcsr_base);

// File: bii_irq_tb.sv
// Self-checking bench for the internal interrupt block
`timescale 1ns/1ns
module bii_irq_tb;
  localparam logic [7:0] PEN = bii_pkg::ADDR_PCI_EN, PST = bii_pkg::ADDR_PCI_STAT, PM1 = bii_pkg::ADDR_PCI_MAP1;
  localparam logic [7:0] VEN = bii_pkg::ADDR_VME_EN, VST = bii_pkg::ADDR_VME_STAT, VM1 = bii_pkg::ADDR_VME_MAP1;
  localparam logic [7:0] MCT = bii_pkg::ADDR_MASTER_CONTROL_REG, LMB = bii_pkg::ADDR_LM_BASE, LMC = bii_pkg::ADDR_LM_CTL;
  localparam logic [1:0] OK = bii_pkg::RESP_OKAY;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, bus_acquired, decoupled_write, vme_bus_error;
  logic pci_abort, autoid_option, iack_hit, sysfail_release, crcsr_enable, bus_ownership_request, hon, monarch;
  logic [7:0] s_axi_awaddr, s_axi_araddr, iack_statid, pci_irq_outputs, seen_id;
  logic [31:0] s_axi_wdata, s_axi_rdata, crcsr_base, rng;
  logic [3:0] s_axi_wstrb, mbox_write, dly;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [5:0] dma_cause, c;
  logic [7:1] vme_irq;
  bii_pkg::bii_vacc_s vme_access;
  bii_pkg::bii_iack_s vme_iack;
  int err_total, n_tests, cyc, i;
  bii_irq dut (.*);
  bii_vme_handler partner (.aclk(aclk), .aresetn(aresetn), .vme_irq(vme_irq), .iack_hit(iack_hit),
    .bus_ownership_request(bus_ownership_request), .iack_statid(iack_statid), .hon(hon), .dly(dly),
    .vme_iack(vme_iack), .bus_acquired(bus_acquired), .statid_ff(seen_id), .monarch_ff(monarch));
  // 50 MHz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xs
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    hb = 1'b0;
    while (!hb) begin
      @(negedge aclk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      if (hb) chk(s_axi_bresp, a > bii_pkg::ADDR_SWID ? bii_pkg::RESP_SLVERR : OK);
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end
  endtask : wr
  // Read and compare data and response; ready lines stay high throughout
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    logic hr, hd;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    hd = 1'b0;
    while (!hd) begin
      @(negedge aclk);
      hr = s_axi_arvalid && s_axi_arready;
      hd = s_axi_rvalid;
      if (hd) chk(s_axi_rdata, e);
      if (hd) chk(s_axi_rresp, r);
      @(posedge aclk);
      if (hr) s_axi_arvalid <= 1'b0;
    end
  endtask : rd
  task automatic ochk(input logic [7:0] p, input logic [6:0] v);
    @(negedge aclk);
    chk(pci_irq_outputs, p);
    chk(vme_irq, v);
    @(posedge aclk);
  endtask : ochk
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, aresetn, hon, autoid_option} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, mbox_write, dma_cause} = '0;
    {decoupled_write, vme_bus_error, pci_abort} = '0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
    vme_access = '0;
    dly = 4'h1;
    rng = 32'hA647;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // All registers clear; a hole answers with an error
    for (i = 0; i < 12; i++) rd(8'(i * 4), 32'h0, OK);
    rd(8'h30, 32'h0, bii_pkg::RESP_SLVERR);
    wr(8'h30, 32'h0);
    // PCI soft on line 5, its acknowledge event on line 2
    wr(PM1, 32'h0000_0015);
    wr(PEN, 32'h1);
    ochk(8'h20, 7'h0);
    rd(PST, 32'h1, OK);
    wr(PEN, 32'h3);
    ochk(8'h20, 7'h0);
    wr(PEN, 32'h2);
    ochk(8'h00, 7'h0);
    wr(PEN, 32'h3);
    ochk(8'h20, 7'h0);
    wr(PEN, 32'h2);
    // VME soft on level 3, handler answers promptly
    wr(VM1, 32'h3);
    wr(bii_pkg::ADDR_SWID, 32'hA5);
    wr(VEN, 32'h1);
    ochk(8'h00, 7'h04);
    hon <= 1'b1;
    repeat (6) @(posedge aclk);
    ochk(8'h04, 7'h0);
    chk(seen_id, 8'hA4);
    rd(PST, 32'h2, OK);
    wr(PST, 32'h2);
    wr(VEN, 32'h1);
    ochk(8'h00, 7'h0);
    wr(VEN, 32'h0);
    // Ownership granted slowly, cleared by writing one
    dly <= 4'h6;
    wr(PEN, 32'h4);
    wr(MCT, 32'h1);
    repeat (10) @(posedge aclk);
    ochk(8'h01, 7'h0);
    wr(MCT, 32'h0);
    wr(PST, 32'h4);
    ochk(8'h00, 7'h0);
    // Random DMA cause mixes, routed to level 4 and line 0
    hon <= 1'b0;
    wr(VM1, 32'h800);
    wr(VEN, 32'h8);
    wr(PEN, 32'h8);
    for (i = 0; i < 6; i++) begin
      c = 6'(xs()) | 6'(1 << i);
      dma_cause <= c;
      @(posedge aclk);
      dma_cause <= 6'h0;
      ochk(8'h01, 7'h08);
      rd(PST, {10'h0, c, 16'h8}, OK);
      rd(VST, {10'h0, c, 16'h8}, OK);
      wr(PST, 32'h8);
      wr(VST, 32'h8);
    end
    // Mailboxes, only the first one routed to level 7
    wr(VM1, 32'h0700_0000);
    wr(VEN, 32'hF00);
    wr(PEN, 32'hF00);
    for (i = 0; i < 4; i++) begin
      mbox_write <= 4'(1 << i);
      @(posedge aclk);
      mbox_write <= 4'h0;
      ochk(8'h01, i == 0 ? 7'h40 : 7'h0);
      rd(VST, 32'h100 << i, OK);
      wr(VST, 32'h100 << i);
      wr(PST, 32'h100 << i);
    end
    // Monitors: four hits, then outside window, wrong space, disabled
    wr(PEN, 32'hF000);
    wr(LMB, 32'h0001_2000);
    wr(LMC, 32'h3);
    for (i = 0; i < 7; i++) begin
      void'(xs());
      if (i == 6) wr(LMC, 32'h2);
      vme_access <= '{1'b1, {i == 4 ? 20'h00013 : 20'h00012, rng[11:5], 2'(i), rng[2:0]}, i == 5 ? 2'h2 : 2'h1};
      @(posedge aclk);
      vme_access.valid <= 1'b0;
      rd(PST, i < 4 ? 32'h1000 << i : 32'h0, OK);
      wr(PST, 32'hF000);
    end
    rd(VST, 32'h0, OK);
    // Bus errors count only during decoupled writes
    wr(PEN, 32'h30);
    for (i = 0; i < 4; i++) begin
      {decoupled_write, vme_bus_error, pci_abort} <= {i[1], !i[0], i[0]};
      @(posedge aclk);
      {decoupled_write, vme_bus_error, pci_abort} <= 3'h0;
      rd(PST, i < 2 ? 32'h0 : 32'h10 << i[0], OK);
      wr(PST, 32'h30);
    end
    // Second power-up with Auto-ID: level 2 first, slow handler
    autoid_option <= 1'b1;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    ochk(8'h00, 7'h02);
    chk(sysfail_release, 1'b0);
    hon <= 1'b1;
    repeat (12) @(posedge aclk);
    @(negedge aclk);
    chk(seen_id, 8'hFE);
    chk({monarch, crcsr_enable, sysfail_release}, 3'h7);
    chk(crcsr_base, 32'h0);
    print_verdict();
  end
endmodule : bii_irq_tb

// File: bii_pkg.sv
// Package for the bridge internal interrupt source block
package bii_pkg;
  // Register byte addresses (word aligned)
  localparam logic [7:0] ADDR_PCI_EN = 8'h00;
  localparam logic [7:0] ADDR_PCI_STAT = 8'h04;
  localparam logic [7:0] ADDR_PCI_MAP1 = 8'h08;
  localparam logic [7:0] ADDR_PCI_MAP2 = 8'h0C;
  localparam logic [7:0] ADDR_VME_EN = 8'h10;
  localparam logic [7:0] ADDR_VME_STAT = 8'h14;
  localparam logic [7:0] ADDR_VME_MAP1 = 8'h18;
  localparam logic [7:0] ADDR_VME_MAP2 = 8'h1C;
  localparam logic [7:0] ADDR_MASTER_CONTROL_REG = 8'h20;
  localparam logic [7:0] ADDR_LM_BASE = 8'h24;
  localparam logic [7:0] ADDR_LM_CTL = 8'h28;
  localparam logic [7:0] ADDR_SWID = 8'h2C;
  // Source bit positions shared by enable and status registers
  localparam int B_SW = 0;
  localparam int B_SWACK = 1;
  localparam int B_OWN = 2;
  localparam int B_DMA = 3;
  localparam int B_VERR = 4;
  localparam int B_LERR = 5;
  localparam int B_MBOX = 8;
  localparam int B_LM = 12;
  localparam int B_DMA_CAUSE = 16;
  localparam int NSRC = 16;
  localparam int NCAUSE = 6;
  // Map field width: 3 bits per source, 8 PCI lines or VME level 1..7
  localparam int MAPW = 3;
  localparam int NPCI = 8;
  localparam int NVME = 8;
  // Control fields: ownership request, monitor enable, space; monitor select is the VME address bit position
  localparam int B_OWN_REQ = 0;
  localparam int B_LM_EN = 0;
  localparam int LM_SPACE_LSB = 1;
  localparam int LM_SEL_LSB = 3;
  // Location monitor window is 4 kbytes
  localparam int LM_SPAN_BITS = 12;
  localparam int VA_W = 32;
  localparam logic [7:0] AUTOID_STATID = 8'hFE;
  localparam logic [2:0] AUTOID_LEVEL = 3'h2;
  localparam logic [31:0] CRCSR_BASE = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // One incoming VME access seen by the slave channel
  typedef struct packed {
    logic valid;
    logic [VA_W-1:0] addr;
    logic [1:0] space;
  } bii_vacc_s;
  // One IACK cycle offered by the VME handler
  typedef struct packed {
    logic valid;
    logic [2:0] level;
  } bii_iack_s;
endpackage : bii_pkg

// File: bii_vme_handler.sv
// Model of the bus arbiter and the VME interrupt handler
`timescale 1ns/1ns
module bii_vme_handler (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:1] vme_irq,
  input wire logic bus_ownership_request,
  input wire logic iack_hit,
  input wire logic [7:0] iack_statid,
  input wire logic hon,
  input wire logic [3:0] dly,
  output bii_pkg::bii_iack_s vme_iack,
  output logic bus_acquired,
  output logic [7:0] statid_ff,
  output logic monarch_ff
);
  logic [3:0] wait_ff;
  logic [3:0] own_ff;
  logic [2:0] top;
  // Highest active level wins the acknowledge
  always_comb begin
    top = 3'h0;
    for (int i = 1; i < 8; i++) if (vme_irq[i]) top = 3'(i);
  end
  // Handler waits dly cycles, then runs one IACK cycle
  always_ff @(posedge aclk) begin
    if (!aresetn || !hon || top == 3'h0 || vme_iack.valid) begin
      wait_ff <= 4'h0;
      vme_iack <= '0;
    end else if (wait_ff == dly) begin
      wait_ff <= 4'h0;
      vme_iack <= '{valid: 1'b1, level: top};
    end else begin
      wait_ff <= wait_ff + 4'h1;
    end
  end
  // Ownership granted dly cycles after the request, dropped with it
  always_ff @(posedge aclk) begin
    own_ff <= (!aresetn || !bus_ownership_request) ? 4'h0 : own_ff + 4'(own_ff != dly);
    bus_acquired <= aresetn && bus_ownership_request && own_ff == dly;
  end
  // Monarch keeps the id; Auto-ID on level 2 sends it to configure the card
  always_ff @(posedge aclk) begin
    statid_ff <= !aresetn ? 8'h00 : iack_hit ? iack_statid : statid_ff;
    monarch_ff <= aresetn && (monarch_ff || (iack_hit && vme_iack.level == 3'h2 && iack_statid == 8'hFE));
  end
endmodule : bii_vme_handler
